/* hdl/ssv_pkg.sv */
/*
  Package for the supply status and voltage command block: condition
  bit positions, command codes, error codes and reset values.
  Assumes a command parser outside that delivers decoded commands with
  numeric arguments already converted to millivolts.
*/
`default_nettype none
package ssv_pkg;
  localparam int unsigned COND_W = 13;
  localparam int unsigned BIT_CONST_VOLT = 0;
  localparam int unsigned BIT_CONST_CURR = 1;
  localparam int unsigned BIT_UNUSED = 2;
  localparam int unsigned BIT_HIGH_OUT = 3;
  localparam int unsigned BIT_THERMAL = 4;
  localparam int unsigned BIT_EXT_SHUTDOWN = 5;
  localparam int unsigned BIT_CUTBACK = 6;
  localparam int unsigned BIT_ERR = 7;
  localparam int unsigned BIT_POWER_UP = 8;
  localparam int unsigned BIT_HOST_CTRL = 9;
  localparam int unsigned BIT_MAINS_LOSS = 10;
  localparam int unsigned BIT_OUT_FAIL = 11;
  localparam int unsigned BIT_SENSE_TRIP = 12;
  // Bits that never reach the fault register, and bits that never exist.
  localparam logic [12:0] FAULT_EXCL = 13'h0300;
  localparam logic [12:0] VALID_BITS = 13'h1ffb;
  localparam logic [12:0] MASK_RESET = 13'h0000;
  localparam int unsigned MV_W = 20;
  localparam logic [19:0] SETPOINT_RESET = 20'h00000;
  localparam int unsigned ERR_W = 4;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_SOFT_LIMIT = 4'h6;
  localparam logic [3:0] ERR_BAD_LIMIT = 4'h7;
  localparam logic [3:0] ERR_ILLEGAL_CAL = 4'hc;
  localparam int unsigned CMD_W = 4;
  typedef enum logic [3:0] {
    SSV_CMD_NOP = 4'h0,
    SSV_CMD_LIVE_Q = 4'h1,
    SSV_CMD_LATCHED_Q = 4'h2,
    SSV_CMD_FAULT_Q = 4'h3,
    SSV_CMD_ERR_Q = 4'h4,
    SSV_CMD_MASK = 4'h5,
    SSV_CMD_UNMASK = 4'h6,
    SSV_CMD_SETPOINT = 4'h7,
    SSV_CMD_SETPOINT_Q = 4'h8,
    SSV_CMD_LIMIT = 4'h9,
    SSV_CMD_LIMIT_Q = 4'ha,
    SSV_CMD_READBACK_Q = 4'hb,
    SSV_CMD_CAL_LOW = 4'hc,
    SSV_CMD_RB_CAL_LOW = 4'hd,
    SSV_CMD_RB_CAL_HIGH = 4'he,
    SSV_CMD_RB_CAL_COMPUTE = 4'hf
  } ssv_cmd_t;
endpackage
`default_nettype wire

/* hdl/ssv_core.sv */
/*
  Condition registers and output voltage command group of a programmable
  supply's serial interface.
  Assumes: the serial parser presents one decoded command per cmd_valid
  pulse with signed millivolt arguments; analog status arrives as levels
  synchronous to clk_sys; the host formats resp_value as a decimal number.
*/
`default_nettype none
module ssv_core #(
  parameter logic [19:0] MODEL_MAX_MV = 20'd60000,
  parameter logic [19:0] CAL_LOW_MV = 20'd600,
  parameter logic [19:0] CAL_HIGH_MV = 20'd57000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [12:0] cond_in,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [12:0] cmd_mask,
  input wire logic signed [20:0] cmd_arg_a,
  input wire logic signed [20:0] cmd_arg_b,
  input wire logic hold_mode,
  input wire logic trigger,
  input wire logic calibration_enable,
  input wire logic [19:0] readback_mv,
  output logic resp_valid,
  output logic [19:0] resp_value,
  output logic [19:0] prog_mv,
  output logic user_polarity,
  output logic error_led,
  output logic [3:0] error_code,
  output logic poll_err,
  output logic [12:0] live_condition_reg,
  output logic [12:0] latched_condition_reg,
  output logic [12:0] fault_capture_reg,
  output logic [12:0] mask_reg,
  output logic [19:0] rb_low_raw,
  output logic [19:0] rb_high_raw,
  output logic signed [20:0] rb_slope,
  output logic signed [20:0] rb_offset
);

  // ****************************************************************
  // Command decode
  // ****************************************************************

  // Magnitude of a signed millivolt argument; the sign is handled apart.
  function automatic logic [19:0] mv_abs(input logic signed [20:0] v);
    logic signed [20:0] a;
    a = (v < 0) ? -v : v;
    return a[19:0];
  endfunction

  logic cmd_is_err_q;
  logic cmd_is_cal;
  logic cal_reject;
  logic set_bad;
  logic set_err;
  logic limit_bad;
  logic [19:0] set_mag;
  logic [19:0] voltage_setpoint;
  logic [19:0] pending_setpoint;
  logic pending_valid;
  logic [19:0] voltage_soft_limit;
  logic [12:0] live_prev;
  logic [12:0] live_now;
  logic err_flag;

  assign cmd_is_err_q = cmd_valid && (cmd_code == ssv_pkg::SSV_CMD_ERR_Q);
  assign cmd_is_cal = cmd_valid && (cmd_code == ssv_pkg::SSV_CMD_CAL_LOW ||
    cmd_code == ssv_pkg::SSV_CMD_RB_CAL_LOW ||
    cmd_code == ssv_pkg::SSV_CMD_RB_CAL_HIGH ||
    cmd_code == ssv_pkg::SSV_CMD_RB_CAL_COMPUTE);
  assign cal_reject = cmd_is_cal && !calibration_enable;
  assign set_mag = mv_abs(cmd_arg_a);
  assign set_bad = cmd_valid && (cmd_code == ssv_pkg::SSV_CMD_SETPOINT) &&
    (set_mag > voltage_soft_limit);
  assign limit_bad = cmd_valid && (cmd_code == ssv_pkg::SSV_CMD_LIMIT) &&
    (cmd_arg_a < 0 || set_mag > MODEL_MAX_MV ||
    set_mag < voltage_setpoint);
  assign set_err = set_bad || limit_bad || cal_reject;

  // ****************************************************************
  // Condition registers
  // ****************************************************************

  // Live view: masked condition levels, error bit from the sticky flag.
  always_comb begin
    live_now = cond_in & mask_reg & ssv_pkg::VALID_BITS;
    live_now[ssv_pkg::BIT_ERR] = err_flag & mask_reg[ssv_pkg::BIT_ERR];
  end

  // Sticky error flag; a new error wins over a clear by the error query.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      err_flag <= 1'b0;
    end else if (set_err) begin
      err_flag <= 1'b1;
    end else if (cmd_is_err_q) begin
      err_flag <= 1'b0;
    end
  end

  // Live register is a registered copy so every output comes from a flop.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      live_condition_reg <= 13'h0000;
      live_prev <= 13'h0000;
    end else begin
      live_condition_reg <= live_now;
      live_prev <= live_now;
    end
  end

  // Latched register accumulates; the query clears it after the snapshot
  // is taken, but a condition active in that cycle is still kept.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latched_condition_reg <= 13'h0000;
    end else if (cmd_valid && cmd_code == ssv_pkg::SSV_CMD_LATCHED_Q) begin
      latched_condition_reg <= live_now;
    end else if (cmd_is_err_q) begin
      latched_condition_reg <= (latched_condition_reg | live_now) &
        ~(13'h0001 << ssv_pkg::BIT_ERR) | (live_now & {13{set_err}});
    end else begin
      latched_condition_reg <= latched_condition_reg | live_now |
        ({13{set_err}} & (13'h0001 << ssv_pkg::BIT_ERR));
    end
  end

  // Fault capture sets on a masked rising edge of a live bit.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_capture_reg <= 13'h0000;
    end else if (cmd_valid && cmd_code == ssv_pkg::SSV_CMD_FAULT_Q) begin
      fault_capture_reg <= live_now & ~live_prev & ~ssv_pkg::FAULT_EXCL;
    end else begin
      fault_capture_reg <= fault_capture_reg |
        (live_now & ~live_prev & ~ssv_pkg::FAULT_EXCL);
    end
  end

  // Mask register, starting with every condition masked off.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_reg <= ssv_pkg::MASK_RESET;
    end else if (cmd_valid && cmd_code == ssv_pkg::SSV_CMD_UNMASK) begin
      mask_reg <= (mask_reg | cmd_mask) & ssv_pkg::VALID_BITS;
    end else if (cmd_valid && cmd_code == ssv_pkg::SSV_CMD_MASK) begin
      mask_reg <= mask_reg & ~cmd_mask;
    end
  end

  // Serial-poll error bit and last error code.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      poll_err <= 1'b0;
      error_led <= 1'b0;
      error_code <= ssv_pkg::ERR_NONE;
    end else if (set_err) begin
      poll_err <= 1'b1;
      error_led <= 1'b1;
      if (cal_reject) begin
        error_code <= ssv_pkg::ERR_ILLEGAL_CAL;
      end else if (set_bad) begin
        error_code <= ssv_pkg::ERR_SOFT_LIMIT;
      end else begin
        error_code <= ssv_pkg::ERR_BAD_LIMIT;
      end
    end else if (cmd_is_err_q) begin
      poll_err <= 1'b0;
      error_led <= 1'b0;
      error_code <= ssv_pkg::ERR_NONE;
    end
  end

  // ****************************************************************
  // Voltage setting group
  // ****************************************************************

  // Soft limit; an illegal value leaves it untouched.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      voltage_soft_limit <= MODEL_MAX_MV;
    end else if (cmd_valid && cmd_code == ssv_pkg::SSV_CMD_LIMIT && !limit_bad) begin
      voltage_soft_limit <= set_mag;
    end
  end

  // Setpoint, optionally held until a trigger; held magnitudes stay hidden, but user_polarity takes the new sign at once.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      voltage_setpoint <= ssv_pkg::SETPOINT_RESET;
      pending_setpoint <= ssv_pkg::SETPOINT_RESET;
      pending_valid <= 1'b0;
      user_polarity <= 1'b0;
    end else if (cmd_valid && cmd_code == ssv_pkg::SSV_CMD_SETPOINT && !set_bad) begin
      user_polarity <= (cmd_arg_a < 0);
      if (hold_mode) begin
        pending_setpoint <= set_mag;
        pending_valid <= 1'b1;
      end else begin
        voltage_setpoint <= set_mag;
      end
    end else if (trigger && pending_valid) begin
      voltage_setpoint <= pending_setpoint;
      pending_valid <= 1'b0;
    end
  end

  // Programmed output: calibration steps override the setpoint.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prog_mv <= ssv_pkg::SETPOINT_RESET;
    end else if (cmd_is_cal && calibration_enable &&
        (cmd_code == ssv_pkg::SSV_CMD_CAL_LOW ||
        cmd_code == ssv_pkg::SSV_CMD_RB_CAL_LOW)) begin
      prog_mv <= CAL_LOW_MV;
    end else if (cmd_is_cal && calibration_enable &&
        cmd_code == ssv_pkg::SSV_CMD_RB_CAL_HIGH) begin
      prog_mv <= CAL_HIGH_MV;
    end else if (cmd_valid && cmd_code == ssv_pkg::SSV_CMD_SETPOINT && !set_bad) begin
      // A held setpoint leaves the output alone until the trigger.
      if (!hold_mode) begin
        prog_mv <= set_mag;
      end
    end else if (trigger && pending_valid) begin
      // A refused setpoint falls through here, so a calibration level
      // on the output is never replaced by an ignored command.
      prog_mv <= pending_setpoint;
    end
  end

  // ****************************************************************
  // Readback calibration
  // ****************************************************************

  // The stored reading is the one present when the step is taken; the
  // host resends the step after settling, which simply refreshes it.
  // Slope is kept as host-span minus raw-span and offset as low error,
  // leaving division to firmware; this trades accuracy work for area.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rb_low_raw <= 20'h00000;
      rb_high_raw <= 20'h00000;
      rb_slope <= 21'sh000000;
      rb_offset <= 21'sh000000;
    end else if (cmd_is_cal && calibration_enable) begin
      case (cmd_code)
        ssv_pkg::SSV_CMD_RB_CAL_LOW: begin
          rb_low_raw <= readback_mv;
        end
        ssv_pkg::SSV_CMD_RB_CAL_HIGH: begin
          rb_high_raw <= readback_mv;
        end
        ssv_pkg::SSV_CMD_RB_CAL_COMPUTE: begin
          rb_slope <= (cmd_arg_b - cmd_arg_a) -
            ($signed({1'b0, rb_high_raw}) - $signed({1'b0, rb_low_raw}));
          rb_offset <= cmd_arg_a - $signed({1'b0, rb_low_raw});
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Query answers
  // ****************************************************************

  // A 13-bit register read as an unsigned number is its bit-weight sum.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_value <= 20'h00000;
    end else begin
      resp_valid <= 1'b0;
      if (cmd_valid) begin
        case (cmd_code)
          ssv_pkg::SSV_CMD_LIVE_Q: begin
            resp_valid <= 1'b1;
            resp_value <= {7'h00, live_now};
          end
          ssv_pkg::SSV_CMD_LATCHED_Q: begin
            resp_valid <= 1'b1;
            resp_value <= {7'h00, latched_condition_reg | live_now};
          end
          ssv_pkg::SSV_CMD_FAULT_Q: begin
            resp_valid <= 1'b1;
            resp_value <= {7'h00, fault_capture_reg};
          end
          ssv_pkg::SSV_CMD_ERR_Q: begin
            resp_valid <= 1'b1;
            resp_value <= {16'h0000, error_code};
          end
          ssv_pkg::SSV_CMD_SETPOINT_Q: begin
            resp_valid <= 1'b1;
            resp_value <= voltage_setpoint;
          end
          ssv_pkg::SSV_CMD_LIMIT_Q: begin
            resp_valid <= 1'b1;
            resp_value <= voltage_soft_limit;
          end
          ssv_pkg::SSV_CMD_READBACK_Q: begin
            resp_valid <= 1'b1;
            resp_value <= readback_mv;
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* bench/ssv_core_monitor.sv */
/*
  Port checker for ssv_core: answer timing, refusals, flags.
  Assumes it is bound to every ssv_core instance.
*/
`default_nettype none
module ssv_core_monitor #(
  parameter logic [19:0] MODEL_MAX_MV = 20'd60000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic signed [20:0] cmd_arg_a,
  input wire logic trigger,
  input wire logic calibration_enable,
  input wire logic resp_valid,
  input wire logic [19:0] resp_value,
  input wire logic [19:0] prog_mv,
  input wire logic user_polarity,
  input wire logic error_led,
  input wire logic [3:0] error_code,
  input wire logic poll_err,
  input wire logic [12:0] live_condition_reg,
  input wire logic [12:0] fault_capture_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic qry;
  logic cal;
  // Query and calibration decodes, kept apart to keep properties short.
  assign qry = cmd_valid && cmd_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'ha, 4'hb};
  assign cal = cmd_valid && cmd_code inside {4'hc, 4'hd, 4'he, 4'hf};
  answer_time_a: assert property (qry |=> resp_valid) else $error("query unanswered");
  no_answer_a: assert property (!qry |=> !resp_valid) else $error("stray answer");
  answer_hold_a: assert property (!resp_valid |-> $stable(resp_value))
    else $error("answer moved");
  dead_bits_a: assert property (!live_condition_reg[2] && !fault_capture_reg[2])
    else $error("dead bit set");
  fault_excl_a: assert property (fault_capture_reg[9:8] == 2'h0)
    else $error("status-only bit in fault");
  cal_refuse_a: assert property (cal && !calibration_enable |=>
    error_code == 4'hc && poll_err) else $error("calibration not refused");
  err_clear_a: assert property (cmd_valid && cmd_code == 4'h4 |=> !poll_err && !error_led)
    else $error("error flag kept");
  polarity_cause_a: assert property ($rose(user_polarity) |->
    $past(cmd_valid && cmd_code == 4'h7 && cmd_arg_a < 0))
    else $error("polarity without cause");
  prog_cause_a: assert property ($changed(prog_mv) |-> $past(cmd_valid || trigger))
    else $error("output moved alone");
  // A trigger in the same cycle may still move the output legitimately.
  over_limit_a: assert property (cmd_valid && cmd_code == 4'h7 && !trigger &&
    cmd_arg_a > $signed({1'b0, MODEL_MAX_MV}) |=> $stable(prog_mv) && error_code == 4'h6)
    else $error("over limit accepted");
  cover property (qry ##1 resp_valid);
  cover property (cal && !calibration_enable);
  cover property ($rose(user_polarity));
endmodule
bind ssv_core ssv_core_monitor #(.MODEL_MAX_MV(MODEL_MAX_MV)) u_mon (.clk_sys, .rst, .cmd_valid,
  .cmd_code, .cmd_arg_a, .trigger, .calibration_enable, .resp_valid, .resp_value, .prog_mv,
  .user_polarity, .error_led, .error_code, .poll_err, .live_condition_reg, .fault_capture_reg);
`default_nettype wire

/* bench/ssv_host.sv */
/*
  Host side model: issues one decoded command per call and
  returns the answer seen 1 ns after the taking edge.
*/
`default_nettype none
module ssv_host (
  input wire logic clk_sys,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [12:0] cmd_mask,
  output logic signed [20:0] cmd_arg_a,
  output logic signed [20:0] cmd_arg_b,
  input wire logic resp_valid,
  input wire logic [19:0] resp_value
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Command strobe
  // ****
  // Idle lines start at zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_mask = 13'h0000;
    cmd_arg_a = 21'sh0;
    cmd_arg_b = 21'sh0;
  end
  // Fields are inverted after the strobe so stale values cannot pass for live ones.
  task automatic issue(input logic [3:0] c, input logic signed [20:0] a, b,
    input logic [12:0] m, output logic v, output logic [19:0] r);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_mask <= m;
    cmd_arg_a <= a;
    cmd_arg_b <= b;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_mask <= ~m;
    cmd_arg_a <= ~a;
    cmd_arg_b <= ~b;
    #1;
    v = resp_valid;
    r = resp_value;
  endtask
endmodule
`default_nettype wire

/* bench/ssv_core_tb.sv */
/*
  Self-checking bench for ssv_core driven through the host model.
  Assumes the default parameter values of the core.
*/
`default_nettype none
module ssv_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, hold_mode, trigger, cal_en, v, resp_valid, user_polarity;
  logic error_led, poll_err, cmd_valid;
  logic [3:0] cmd_code, error_code;
  logic [12:0] cond_in, cmd_mask, live, latched, fault, mask_reg;
  logic signed [20:0] cmd_arg_a, cmd_arg_b, rb_slope, rb_offset;
  logic [19:0] readback_mv, r, resp_value, prog_mv, rb_low_raw, rb_high_raw;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  ssv_core dut (.clk_sys, .rst, .cond_in, .cmd_valid, .cmd_code, .cmd_mask, .cmd_arg_a,
    .cmd_arg_b, .hold_mode, .trigger, .calibration_enable(cal_en), .readback_mv,
    .resp_valid, .resp_value, .prog_mv, .user_polarity, .error_led, .error_code, .poll_err,
    .live_condition_reg(live), .latched_condition_reg(latched), .fault_capture_reg(fault),
    .mask_reg, .rb_low_raw, .rb_high_raw, .rb_slope, .rb_offset);
  ssv_host host (.clk_sys, .cmd_valid, .cmd_code, .cmd_mask, .cmd_arg_a, .cmd_arg_b,
    .resp_valid, .resp_value);
  // ****
  // Helpers
  // ****
  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [19:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic q(input logic [3:0] c, input logic [19:0] e);
    host.issue(c, 21'sh0, 21'sh0, 13'h0000, v, r);
    chk("resp_valid", 20'h1, 20'(v));
    chk("resp_value", e, r);
  endtask
  task automatic cmd(input logic [3:0] c, input logic signed [20:0] a, input logic [12:0] m);
    host.issue(c, a, 21'sh0, m, v, r);
    chk("no_answer", 20'h0, 20'(v));
  endtask
  // Free-running clock at 20 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // A hang counts as a mismatch; the run needs under a hundred cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {rst, hold_mode, trigger, cal_en, cond_in, readback_mv} = {4'h8, 13'h0, 20'h0};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("prog_mv", 20'h0, prog_mv);
    q(4'ha, 20'd60000);
    @(posedge clk_sys) cond_in <= 13'h1fff;
    repeat (3) @(posedge clk_sys);
    q(4'h1, 20'h0);
    cmd(4'h6, 21'sh0, 13'h1fff);
    chk("mask_reg", 20'h01ffb, 20'(mask_reg));
    q(4'h1, 20'h01f7b);
    chk("live", 20'h01f7b, 20'(live));
    q(4'h3, 20'h01c7b);
    q(4'h3, 20'h0);
    chk("fault", 20'h0, 20'(fault));
    @(posedge clk_sys) cond_in <= 13'h0000;
    repeat (3) @(posedge clk_sys);
    q(4'h2, 20'h01f7b);
    q(4'h2, 20'h0);
    chk("latched", 20'h0, 20'(latched));
    q(4'h1, 20'h0);
    cmd(4'h5, 21'sh0, 13'h0001);
    @(posedge clk_sys) cond_in <= 13'h0003;
    repeat (3) @(posedge clk_sys);
    q(4'h1, 20'h2);
    cmd(4'h7, 21'sd5000, 13'h0);
    chk("prog_mv", 20'd5000, prog_mv);
    q(4'h8, 20'd5000);
    cmd(4'h9, 21'sd4000, 13'h0);
    chk("error_code", 20'h7, 20'(error_code));
    chk("error_led", 20'h1, 20'(error_led));
    q(4'ha, 20'd60000);
    q(4'h1, 20'd130);
    q(4'h4, 20'h7);
    chk("poll_err", 20'h0, 20'(poll_err));
    q(4'h1, 20'h2);
    q(4'h2, 20'h2);
    cmd(4'h7, 21'sd60001, 13'h0);
    chk("error_code", 20'h6, 20'(error_code));
    chk("prog_mv", 20'd5000, prog_mv);
    cmd(4'h7, -21'sd3000, 13'h0);
    chk("user_polarity", 20'h1, 20'(user_polarity));
    chk("prog_mv", 20'd3000, prog_mv);
    @(posedge clk_sys) hold_mode <= 1'b1;
    cmd(4'h7, 21'sd2000, 13'h0);
    q(4'h8, 20'd3000);
    @(posedge clk_sys) trigger <= 1'b1;
    @(posedge clk_sys) trigger <= 1'b0;
    #1 chk("prog_mv", 20'd2000, prog_mv);
    readback_mv <= 20'd12345;
    q(4'hb, 20'd12345);
    cmd(4'hc, 21'sh0, 13'h0);
    chk("error_code", 20'hc, 20'(error_code));
    @(posedge clk_sys) cal_en <= 1'b1;
    cmd(4'hc, 21'sh0, 13'h0);
    chk("prog_mv", 20'd600, prog_mv);
    readback_mv <= 20'd610;
    cmd(4'hd, 21'sh0, 13'h0);
    chk("rb_low_raw", 20'd610, rb_low_raw);
    readback_mv <= 20'd56900;
    cmd(4'he, 21'sh0, 13'h0);
    chk("rb_high_raw", 20'd56900, rb_high_raw);
    chk("prog_mv", 20'd57000, prog_mv);
    host.issue(4'hf, 21'sd598, 21'sd57010, 13'h0, v, r);
    chk("rb_slope", 20'd122, rb_slope[19:0]);
    chk("rb_offset", 20'hffff4, rb_offset[19:0]);
    // A refused setpoint must not disturb the calibration level on the output.
    cmd(4'h7, 21'sd60001, 13'h0);
    chk("prog_mv", 20'd57000, prog_mv);
    finish_test();
  end
endmodule
`default_nettype wire
